/* File: hdl/mip_consts.svh */
/*
 Constants of the maskable interrupt resolver: source count and reset index, default priority
 numbers and vector table addresses for priorities 24 to 44.
 Assumes it is included by bare name wherever these figures are needed.
*/
`ifndef MIP_CONSTS_SVH
`define MIP_CONSTS_SVH

`define MIP_NSRC        21
`define MIP_PRIO_LAST   6'd47
`define MIP_PRIO_BASE   6'd24

`define MIP_PRIO_CONV   6'd24
`define MIP_PRIO_RTCC   6'd25
`define MIP_PRIO_RTCI   6'd26
`define MIP_PRIO_KEY    6'd27
`define MIP_PRIO_SER2T  6'd28
`define MIP_PRIO_RC3E   6'd29
`define MIP_PRIO_RC3V   6'd30
`define MIP_PRIO_T0C4   6'd31
`define MIP_PRIO_SER2R  6'd35
`define MIP_PRIO_PIN7   6'd36
`define MIP_PRIO_RC2E   6'd38
`define MIP_PRIO_RC2V   6'd39
`define MIP_PRIO_RC1E   6'd40
`define MIP_PRIO_T1C0   6'd41
`define MIP_PRIO_SER2E  6'd44

`define MIP_VEC_CONV    16'h0034
`define MIP_VEC_RTCC    16'h0036
`define MIP_VEC_RTCI    16'h0038
`define MIP_VEC_KEY     16'h003a
`define MIP_VEC_SER2T   16'h003c
`define MIP_VEC_RC3E    16'h003e
`define MIP_VEC_RC3V    16'h0040
`define MIP_VEC_T0C4    16'h0042
`define MIP_VEC_T0C5    16'h0044
`define MIP_VEC_T0C6    16'h0046
`define MIP_VEC_T0C7    16'h0048
`define MIP_VEC_SER2R   16'h004a
`define MIP_VEC_PIN7    16'h004c
`define MIP_VEC_PIN8    16'h004e
`define MIP_VEC_RC2E    16'h0050
`define MIP_VEC_RC2V    16'h0052
`define MIP_VEC_RC1E    16'h0054
`define MIP_VEC_T1C0    16'h0056
`define MIP_VEC_T1C1    16'h0058
`define MIP_VEC_T1C2    16'h005a
`define MIP_VEC_SER2E   16'h005c

`define MIP_VEC_RST     16'h0000
`define MIP_IDX_RST     5'd0

`endif

/* File: hdl/mip_irq_ctrl.sv */
/*
 Maskable interrupt resolver for default priorities 24 to 44: latches
 peripheral events, ranks them and offers the winning vector to the core.
 Assumes all requests are one-cycle pulses synchronous to clk_i and that
 masking is applied upstream.
*/
// What this block does
// R1: Requests arriving together are serviced in fixed default priority order.
// R2: Priority zero is most urgent, forty-seven least; lower number wins ties.
// R3: Conversion done is internal, priority 24, vector 0034H.
// R4: Real-time counter cycle or alarm is priority 25, vector 0036H.
// R5: Real-time counter interval is priority 26, vector 0038H.
// R6: Key input is external, priority 27, vector 003AH.
// R7: Serial 2 transmit, clocked and two-wire ends share priority 28, 003CH.
// R8: Remote channel 3 error is priority 29, vector 003EH.
// R9: Remote channel 3 events share priority 30, vector 0040H.
// R10: First timer channels 4 to 7 take priorities 31-34, vectors 0042H-0048H.
// R11: Serial 2 receive end is priority 35, vector 004AH.
// R12: Pin 7 and 8 edges are external, priorities 36, 37, vectors 004CH, 004EH.
// R13: Remote channel 2 error is priority 38, vector 0050H.
// R14: Remote channel 2 events share priority 39, vector 0052H.
// R15: Remote channel 1 error is priority 40, vector 0054H.
// R16: Second timer channels 0 to 2 take priorities 41-43, vectors 0056H-005AH.
// R17: Serial 2 receive error is priority 44, vector 005CH.
// R18: On acknowledge, the core gets the vector of the lowest-numbered pending request; the code gives the offer picked from the flags a cycle earlier.
`timescale 1ns/1ps
`include "mip_consts.svh"

module mip_irq_ctrl
   import mip_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        conv_done_irq_i,
   input  wire logic        rtc_cycle_alarm_irq_i,
   input  wire logic        rtc_interval_irq_i,
   input  wire logic        key_input_irq_i,
   input  wire logic        ser2_async_tx_irq_i,
   input  wire logic        ser2_clocked_irq_i,
   input  wire logic        ser2_twowire_irq_i,
   input  wire logic        rc3_error_irq_i,
   input  wire logic        rc3_event_irq_i,
   input  wire logic        tmr0_ch4_irq_i,
   input  wire logic        tmr0_ch5_irq_i,
   input  wire logic        tmr0_ch6_irq_i,
   input  wire logic        tmr0_ch7_irq_i,
   input  wire logic        ser2_async_rx_irq_i,
   input  wire logic        pin7_edge_irq_i,
   input  wire logic        pin8_edge_irq_i,
   input  wire logic        rc2_error_irq_i,
   input  wire logic        rc2_event_irq_i,
   input  wire logic        rc1_error_irq_i,
   input  wire logic        tmr1_ch0_irq_i,
   input  wire logic        tmr1_ch1_irq_i,
   input  wire logic        tmr1_ch2_irq_i,
   input  wire logic        ser2_rx_error_irq_i,
   input  wire logic        ack_i,
   output logic             irq_req_o,
   output logic [15:0]      vec_o,
   output logic [5:0]       prio_o,
   output logic             ext_src_o,
   output logic             ack_done_o,
   output logic [15:0]      ack_vec_o,
   output mip_req_t         pending_o
);

   mip_req_t   set_req;
   mip_req_t   clr_req;
   mip_req_t   pend;
   logic       pick_any;
   logic [4:0] pick_idx;
   mip_grant_s cand;
   mip_grant_s offer_reg;
   mip_state_e state_reg;
   mip_state_e state_next;
   logic       take;

   // An acknowledge counts only while an offer stands; a stray one is dropped
   assign take = (state_reg == MIP_OFFER) && ack_i;

   // Line index equals default priority minus 24
   always_comb begin
      set_req     = '0;
      set_req[0]  = conv_done_irq_i;                                    // [R3]
      set_req[1]  = rtc_cycle_alarm_irq_i;                              // [R4]
      set_req[2]  = rtc_interval_irq_i;                                 // [R5]
      set_req[3]  = key_input_irq_i;                                    // [R6]
      set_req[4]  = ser2_async_tx_irq_i | ser2_clocked_irq_i
                  | ser2_twowire_irq_i;                                 // [R7]
      set_req[5]  = rc3_error_irq_i;                                    // [R8]
      set_req[6]  = rc3_event_irq_i;                                    // [R9]
      set_req[7]  = tmr0_ch4_irq_i;                                     // [R10]
      set_req[8]  = tmr0_ch5_irq_i;                                     // [R10]
      set_req[9]  = tmr0_ch6_irq_i;                                     // [R10]
      set_req[10] = tmr0_ch7_irq_i;                                     // [R10]
      set_req[11] = ser2_async_rx_irq_i;                                // [R11]
      set_req[12] = pin7_edge_irq_i;                                    // [R12]
      set_req[13] = pin8_edge_irq_i;                                    // [R12]
      set_req[14] = rc2_error_irq_i;                                    // [R13]
      set_req[15] = rc2_event_irq_i;                                    // [R14]
      set_req[16] = rc1_error_irq_i;                                    // [R15]
      set_req[17] = tmr1_ch0_irq_i;                                     // [R16]
      set_req[18] = tmr1_ch1_irq_i;                                     // [R16]
      set_req[19] = tmr1_ch2_irq_i;                                     // [R16]
      set_req[20] = ser2_rx_error_irq_i;                                // [R17]
   end

   // Per-line table: default priority, vector and source kind side by side
   function automatic mip_grant_s mip_desc_of(input logic [4:0] idx);
      mip_grant_s d;
      d     = '0;
      d.idx = idx;
      case (idx)
         // Converter and real-time counter lines are internal
         5'h00: begin // [R3]
            d.prio = `MIP_PRIO_CONV;
            d.vec  = `MIP_VEC_CONV;
            d.ext  = 1'b0;
         end
         5'h01: begin // [R4]
            d.prio = `MIP_PRIO_RTCC;
            d.vec  = `MIP_VEC_RTCC;
            d.ext  = 1'b0;
         end
         5'h02: begin // [R5]
            d.prio = `MIP_PRIO_RTCI;
            d.vec  = `MIP_VEC_RTCI;
            d.ext  = 1'b0;
         end

         // Key return is an external source
         5'h03: begin // [R6]
            d.prio = `MIP_PRIO_KEY;
            d.vec  = `MIP_VEC_KEY;
            d.ext  = 1'b1;
         end

         // Three serial channel 2 end events share this line
         5'h04: begin // [R7]
            d.prio = `MIP_PRIO_SER2T;
            d.vec  = `MIP_VEC_SER2T;
            d.ext  = 1'b0;
         end

         // Remote-control channel 3 error, then its events
         5'h05: begin // [R8]
            d.prio = `MIP_PRIO_RC3E;
            d.vec  = `MIP_VEC_RC3E;
            d.ext  = 1'b0;
         end
         5'h06: begin // [R9]
            d.prio = `MIP_PRIO_RC3V;
            d.vec  = `MIP_VEC_RC3V;
            d.ext  = 1'b0;
         end

         // First timer array channels 4 to 7 on consecutive numbers
         5'h07: begin // [R10]
            d.prio = `MIP_PRIO_T0C4;
            d.vec  = `MIP_VEC_T0C4;
            d.ext  = 1'b0;
         end
         5'h08: begin // [R10]
            d.prio = `MIP_PRIO_T0C4 + 6'd1;
            d.vec  = `MIP_VEC_T0C5;
            d.ext  = 1'b0;
         end
         5'h09: begin // [R10]
            d.prio = `MIP_PRIO_T0C4 + 6'd2;
            d.vec  = `MIP_VEC_T0C6;
            d.ext  = 1'b0;
         end
         5'h0a: begin // [R10]
            d.prio = `MIP_PRIO_T0C4 + 6'd3;
            d.vec  = `MIP_VEC_T0C7;
            d.ext  = 1'b0;
         end

         // Serial channel 2 receive end
         5'h0b: begin // [R11]
            d.prio = `MIP_PRIO_SER2R;
            d.vec  = `MIP_VEC_SER2R;
            d.ext  = 1'b0;
         end

         // Pin 7 and pin 8 edges are external sources
         5'h0c: begin // [R12]
            d.prio = `MIP_PRIO_PIN7;
            d.vec  = `MIP_VEC_PIN7;
            d.ext  = 1'b1;
         end
         5'h0d: begin // [R12]
            d.prio = `MIP_PRIO_PIN7 + 6'd1;
            d.vec  = `MIP_VEC_PIN8;
            d.ext  = 1'b1;
         end

         // Remote-control channel 2 error, then its events
         5'h0e: begin // [R13]
            d.prio = `MIP_PRIO_RC2E;
            d.vec  = `MIP_VEC_RC2E;
            d.ext  = 1'b0;
         end
         5'h0f: begin // [R14]
            d.prio = `MIP_PRIO_RC2V;
            d.vec  = `MIP_VEC_RC2V;
            d.ext  = 1'b0;
         end

         // Remote-control channel 1 error
         5'h10: begin // [R15]
            d.prio = `MIP_PRIO_RC1E;
            d.vec  = `MIP_VEC_RC1E;
            d.ext  = 1'b0;
         end

         // Second timer array channels 0 to 2 on consecutive numbers
         5'h11: begin // [R16]
            d.prio = `MIP_PRIO_T1C0;
            d.vec  = `MIP_VEC_T1C0;
            d.ext  = 1'b0;
         end
         5'h12: begin // [R16]
            d.prio = `MIP_PRIO_T1C0 + 6'd1;
            d.vec  = `MIP_VEC_T1C1;
            d.ext  = 1'b0;
         end
         5'h13: begin // [R16]
            d.prio = `MIP_PRIO_T1C0 + 6'd2;
            d.vec  = `MIP_VEC_T1C2;
            d.ext  = 1'b0;
         end

         // Serial channel 2 receive error is the least urgent line here
         5'h14: begin // [R17]
            d.prio = `MIP_PRIO_SER2E;
            d.vec  = `MIP_VEC_SER2E;
            d.ext  = 1'b0;
         end

         default: d.vec = `MIP_VEC_RST;
      endcase
      return d;
   endfunction : mip_desc_of

   mip_pending u_pending (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .set_i   (set_req),
      .clr_i   (clr_req),
      .pend_o  (pend)
   );

   mip_prio_pick u_pick (
      .pend_i  (pend),
      .any_o   (pick_any),
      .idx_o   (pick_idx)                                               // [R1] [R2]
   );

   always_comb begin
      cand       = mip_desc_of(pick_idx);                               // [R2]
      cand.valid = pick_any;
   end

   // Only the line being offered is cleared, and only in the ack cycle
   always_comb begin
      clr_req = '0;
      if (take) begin
         clr_req[offer_reg.idx] = 1'b1;                                 // [R18]
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         MIP_IDLE: begin
            if (pick_any) begin
               state_next = MIP_OFFER;
            end
         end
         MIP_OFFER: begin
            if (ack_i) begin
               state_next = MIP_TAKEN;
            end
         end
         MIP_TAKEN: begin
            // One cycle so the cleared flag leaves the pick before a new offer
            state_next = MIP_IDLE;
         end
         default: state_next = MIP_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= MIP_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // The offer follows the current winner until taken, so a more urgent
   // late arrival still overtakes a waiting one
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         offer_reg <= '0;
      end else if (state_next == MIP_OFFER && !take) begin
         offer_reg <= cand;                                             // [R1] [R18]
      end else if (state_next != MIP_OFFER) begin
         offer_reg.valid <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_done_o <= 1'b0;
      end else begin
         ack_done_o <= take;
      end
   end

   // The taken vector stays until the next acknowledge
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_vec_o <= `MIP_VEC_RST;
      end else if (take) begin
         ack_vec_o <= offer_reg.vec;                                    // [R18]
      end
   end

   always_comb begin
      irq_req_o = offer_reg.valid;
      vec_o     = offer_reg.vec;
      prio_o    = offer_reg.prio;
      ext_src_o = offer_reg.ext;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pending_o <= '0;
      end else begin
         pending_o <= pend;
      end
   end

endmodule : mip_irq_ctrl

/* File: hdl/mip_pending.sv */
/*
 Sticky pending flags, one per request line.
 Assumes set and clear are synchronous one-cycle pulses.
*/
`timescale 1ns/1ps
`include "mip_consts.svh"

module mip_pending
   import mip_pkg::*;
(
   input  wire logic     clk_i,
   input  wire logic     rst_n_i,
   input  wire mip_req_t set_i,
   input  wire mip_req_t clr_i,
   output mip_req_t      pend_o
);

   genvar g;
   generate
      for (g = 0; g < `MIP_NSRC; g = g + 1) begin : g_flag
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               pend_o[g] <= 1'b0;
            end else if (set_i[g]) begin
               // A fresh event beats an acknowledge in the same cycle
               pend_o[g] <= 1'b1;
            end else if (clr_i[g]) begin
               pend_o[g] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule : mip_pending

/* File: hdl/mip_pkg.sv */
/*
 Types of the maskable interrupt resolver.
 Assumes mip_consts.svh provides the figures.
*/
`include "mip_consts.svh"

package mip_pkg;

   typedef logic [`MIP_NSRC-1:0] mip_req_t;

   typedef enum logic [1:0] {
      MIP_IDLE  = 2'b00,
      MIP_OFFER = 2'b01,
      MIP_TAKEN = 2'b11
   } mip_state_e;

   typedef struct packed {
      logic        valid;
      logic [4:0]  idx;
      logic [5:0]  prio;
      logic [15:0] vec;
      logic        ext;
   } mip_grant_s;

endpackage : mip_pkg

/* File: hdl/mip_prio_pick.sv */
/*
 Fixed-priority pick: index 0 is the most urgent line.
 Assumes line index i carries default priority 24 plus i.
*/
`timescale 1ns/1ps
`include "mip_consts.svh"

module mip_prio_pick
   import mip_pkg::*;
(
   input  wire mip_req_t   pend_i,
   output logic            any_o,
   output logic [4:0]      idx_o
);

   always_comb begin
      any_o = 1'b0;
      idx_o = `MIP_IDX_RST;
      // Scan from the least urgent upward so the lowest number is kept last
      for (int i = `MIP_NSRC - 1; i >= 0; i--) begin
         if (pend_i[i]) begin
            any_o = 1'b1;
            idx_o = 5'(i);
         end
      end
   end

endmodule : mip_prio_pick

/* File: verif/mip_core_model.sv */
/*
 Core-side acknowledge model for the interrupt resolver.
 Assumes one clock and an active-low asynchronous reset shared with the resolver.
*/
`timescale 1ns/1ps

module mip_core_model (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic irq_req_i,
   input  wire logic slow_i,
   input  wire logic stray_i,
   output logic      ack_o
);
   logic [1:0] wait_q;

   // Slow mode lets the resolver re-pick before the acknowledge lands
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o  <= 1'b0;
         wait_q <= 2'd0;
      end else if (ack_o) begin
         ack_o  <= 1'b0;
         wait_q <= 2'd0;
      end else if (irq_req_i && (!slow_i || wait_q == 2'd3)) begin
         ack_o <= 1'b1;
      end else begin
         ack_o  <= stray_i && !irq_req_i;
         wait_q <= irq_req_i ? wait_q + 2'd1 : 2'd0;
      end
   end
endmodule : mip_core_model

/* File: verif/mip_irq_ctrl_checker.sv */
/*
 Port-level assertions for the interrupt resolver.
 Assumes it is bound to mip_irq_ctrl and sees only its ports.
*/
`timescale 1ns/1ps

module mip_irq_ctrl_checker
   import mip_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        conv_done_irq_i,
   input wire logic        ser2_async_tx_irq_i,
   input wire logic        ser2_clocked_irq_i,
   input wire logic        ser2_twowire_irq_i,
   input wire logic        ack_i,
   input wire logic        irq_req_o,
   input wire logic [15:0] vec_o,
   input wire logic [5:0]  prio_o,
   input wire logic        ext_src_o,
   input wire logic        ack_done_o,
   input wire logic [15:0] ack_vec_o,
   input wire mip_req_t    pending_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   logic took;
   logic ser2_any;
   assign took     = ack_i && irq_req_o;
   assign ser2_any = ser2_async_tx_irq_i || ser2_clocked_irq_i || ser2_twowire_irq_i;

   a_ack_done_pulse: assert property (took |=> ack_done_o ##1 !ack_done_o)
      else $error("acknowledge not answered by a single done pulse");
   a_ack_vec_take: assert property (took |=> ack_vec_o == $past(vec_o))
      else $error("taken vector differs from offered vector");
   a_drop_after_ack: assert property (took |=> !irq_req_o [*2])
      else $error("request not withdrawn after acknowledge");
   a_vec_prio_pair: assert property (irq_req_o |-> vec_o == {9'h0, prio_o, 1'b0} + 16'h4)
      else $error("vector does not match priority");
   a_prio_range: assert property (irq_req_o |-> prio_o >= 6'd24 && prio_o <= 6'd44)
      else $error("offered priority out of range");
   a_ext_kind: assert property (irq_req_o |-> ext_src_o == (prio_o == 6'd27 ||
      prio_o == 6'd36 || prio_o == 6'd37))
      else $error("external flag wrong for offered source");
   a_conv_wins: assert property ((conv_done_irq_i && irq_req_o && !ack_i) ##1 !ack_i
      |-> ##[1:2] vec_o == 16'h0034)
      else $error("conversion request did not take over the offer");
   a_ser2_shared: assert property (ser2_any |-> ##2 pending_o[4])
      else $error("serial channel 2 event not pending on shared line");
   a_offer_stands: assert property (irq_req_o && !ack_i |=> irq_req_o)
      else $error("offer withdrawn without acknowledge");
   a_stray_ignored: assert property (ack_i && !irq_req_o |=> !ack_done_o)
      else $error("acknowledge without offer was taken");

   c_ext_taken: cover property (took && ext_src_o);
   c_stray_ack: cover property (ack_i && !irq_req_o);
   c_last_prio: cover property (took && prio_o == 6'd44);
endmodule : mip_irq_ctrl_checker

bind mip_irq_ctrl mip_irq_ctrl_checker i_mip_irq_ctrl_checker (.clk_i, .rst_n_i,
   .conv_done_irq_i, .ser2_async_tx_irq_i, .ser2_clocked_irq_i, .ser2_twowire_irq_i,
   .ack_i, .irq_req_o, .vec_o, .prio_o, .ext_src_o, .ack_done_o, .ack_vec_o, .pending_o);

/* File: verif/tb_top.sv */
/*
 Self-checking bench for the interrupt resolver with a core acknowledge model.
 Assumes the resolver and the core model share clk_i and rst_n_i.
*/
`timescale 1ns/1ps

module tb_top;
   import mip_pkg::*;
   logic        clk_i = 1'b0, rst_n_i = 1'b0, slow = 1'b0, stray = 1'b0, ack;
   logic [22:0] ev = '0;
   logic        irq_req_o, ext_src_o, ack_done_o;
   logic [15:0] vec_o, ack_vec_o, exp_vec;
   logic [5:0]  prio_o;
   mip_req_t    pending_o;
   logic [20:0] model = '0;
   logic [31:0] seed = 32'hd810;
   logic [31:0] r;
   int          fail_count = 0, total_checks = 0, k;

   always #50 clk_i = ~clk_i;

   mip_irq_ctrl i_mip_irq_ctrl (.clk_i, .rst_n_i,
      .conv_done_irq_i(ev[0]), .rtc_cycle_alarm_irq_i(ev[1]), .rtc_interval_irq_i(ev[2]),
      .key_input_irq_i(ev[3]), .ser2_async_tx_irq_i(ev[4]), .ser2_clocked_irq_i(ev[5]),
      .ser2_twowire_irq_i(ev[6]), .rc3_error_irq_i(ev[7]), .rc3_event_irq_i(ev[8]),
      .tmr0_ch4_irq_i(ev[9]), .tmr0_ch5_irq_i(ev[10]), .tmr0_ch6_irq_i(ev[11]),
      .tmr0_ch7_irq_i(ev[12]), .ser2_async_rx_irq_i(ev[13]), .pin7_edge_irq_i(ev[14]),
      .pin8_edge_irq_i(ev[15]), .rc2_error_irq_i(ev[16]), .rc2_event_irq_i(ev[17]),
      .rc1_error_irq_i(ev[18]), .tmr1_ch0_irq_i(ev[19]), .tmr1_ch1_irq_i(ev[20]),
      .tmr1_ch2_irq_i(ev[21]), .ser2_rx_error_irq_i(ev[22]), .ack_i(ack), .irq_req_o,
      .vec_o, .prio_o, .ext_src_o, .ack_done_o, .ack_vec_o, .pending_o);

   mip_core_model i_mip_core_model (.clk_i, .rst_n_i, .irq_req_i(irq_req_o),
      .slow_i(slow), .stray_i(stray), .ack_o(ack));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Three serial channel 2 events fold onto one line
   function automatic int idx_of(int j);
      return j < 4 ? j : (j < 7 ? 4 : j - 2);
   endfunction : idx_of

   function automatic int low(logic [20:0] m);
      for (int i = 0; i < 21; i++) if (m[i]) return i;
      return 21;
   endfunction : low

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out

   always @(posedge clk_i) begin
      if (ack_done_o === 1'b1) chk(32'(ack_vec_o), 32'(exp_vec), "taken vector");
      if (ack === 1'b1 && irq_req_o === 1'b1) begin
         k = low(model);
         exp_vec = 16'h0034 + 16'(2 * k);
         chk(32'(vec_o), 32'(exp_vec), "offered vector");
         chk(32'(prio_o), 32'(24 + k), "offered priority");
         chk(32'(ext_src_o), 32'(k == 3 || k == 12 || k == 13), "source kind");
         if (k < 21) model[k] = 1'b0;
      end
   end

   task automatic fire(input logic [22:0] m, input bit twice);
      @(posedge clk_i);
      ev <= m;
      for (int j = 0; j < 23; j++) if (m[j]) model[idx_of(j)] = 1'b1;
      if (twice) @(posedge clk_i);
      @(posedge clk_i);
      ev <= '0;
   endtask : fire

   task automatic drain();
      int n;
      logic [31:0] q;
      n = 0;
      while ((model != '0 || irq_req_o !== 1'b0) && n < 3000) begin
         @(posedge clk_i);
         q = rnd();
         stray <= q[0] & q[1];
         n++;
      end
      @(posedge clk_i);
      stray <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(32'(pending_o), 32'h0, "pending after drain");
      chk(32'(irq_req_o), 32'h0, "request after drain");
   endtask : drain

   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int j = 0; j < 23; j++) begin
         slow <= j[0];
         fire(23'(1) << j, 1'b0);
         drain();
      end
      repeat (30) begin
         r = rnd();
         slow <= r[23];
         fire(r[22:0], r[24]);
         drain();
      end
      slow <= 1'b1;
      fire(23'h400000, 1'b0);
      fire(23'h000001, 1'b0);
      drain();
      fire(23'h7fffff, 1'b0);
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b0;
      @(posedge clk_i);
      model = '0;
      @(posedge clk_i);
      chk(32'(irq_req_o), 32'h0, "request in reset");
      chk(32'(pending_o), 32'h0, "pending in reset");
      rst_n_i <= 1'b1;
      fire(23'h400000, 1'b0);
      drain();
      close_out();
   end

   // Longest legal run is a few thousand cycles
   initial begin
      repeat (30000) @(posedge clk_i);
      fail_count++;
      close_out();
   end
endmodule : tb_top
